// [epwm_defs.vh]
// Register map, field positions, reset values and encodings for the enhanced PWM block.
// Assumes a 32-bit APB slave with one aligned word per 8-bit register.
`ifndef EPWM_DEFS_VH
`define EPWM_DEFS_VH

// Byte offsets of the registers on the APB bus.
`define OFS_SHUTDOWN_CONTROL   12'h000
`define OFS_MODE_CONTROL       12'h004
`define OFS_TIMER_SELECT       12'h008
`define OFS_TIMER_PERIOD       12'h00c
`define OFS_STEERING_CONTROL   12'h010
`define OFS_RESTART_DEADBAND   12'h014
`define OFS_TIMER_CONTROL      12'h018
`define OFS_TIMER_COUNT        12'h01c
`define OFS_DUTY_UPPER         12'h020
`define OFS_PIN_DIRECTION      12'h024
`define OFS_STATUS             12'h028

// Field positions in the shutdown control register.
`define SD_STATUS_BIT          7
`define SD_SRC_HI              6
`define SD_SRC_LO              4
`define SD_AC_HI               3
`define SD_AC_LO               2
`define SD_BD_HI               1
`define SD_BD_LO               0

// Field positions in the mode control register.
`define MC_CFG_HI              7
`define MC_CFG_LO              6
`define MC_DUTY_HI             5
`define MC_DUTY_LO             4
`define MC_MODE_HI             3
`define MC_MODE_LO             0

// Other field positions.
`define RD_RESTART_BIT         7
`define ST_SYNC_BIT            4
`define TC_ON_BIT              2

// Reset values.
`define RST_STEERING           8'h01
`define RST_PIN_DIRECTION      4'hf
`define RST_ZERO8              8'h00

// Shutdown drive states of a pin pair.
`define SDS_DRIVE0             2'h0
`define SDS_DRIVE1             2'h1

// Shutdown source encodings.
`define SRC_OFF                3'h0
`define SRC_CMP1               3'h1
`define SRC_CMP2               3'h2
`define SRC_CMP_ANY            3'h3
`define SRC_FAULT              3'h4
`define SRC_FAULT_CMP1         3'h5
`define SRC_FAULT_CMP2         3'h6
`define SRC_FAULT_ANY          3'h7

// Output configurations.
`define CFG_SINGLE             2'h0
`define CFG_HALF               2'h2

// Timer select value that picks the local period timer.
`define TSEL_LOCAL             2'h0

`endif

// [epwm_core.v]
// Enhanced PWM unit: APB registers, period timer, duty compare, dead-band,
// steering, auto-shutdown and auto-restart, and pin drivers with enables.
// Assumes fault and comparator inputs are asynchronous; everything else is on i_clk.
//
// How it works
// - Mode low bits set pair polarities
// - Output latches undefined before first period
// - Timer flag set as third period starts
// - All pins high impedance after reset
// - Timer select zero picks local timer
// - Period comes from timer period register
// - Source field disables or picks shutdown trigger
// - Two fields give pair shutdown states
// - Setup forces shutdown with safe states
// - Ten-bit duty from upper register plus bits
// - Half-bridge dead-band from seven-bit field
// - Timer prescales, counts only when on
// - Pin drives only when direction bit clear
// - Steering enable per pin gates signal in single output configuration
// - Status follows condition under auto-restart
// - Shutdown drives pairs to programmed states
// - Sync bit delays steering to next period
// - Fault low, comparator or firmware shuts down
`timescale 1ns/10ps
`include "epwm_defs.vh"

module epwm_core (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_fault_input_pin,
  input  wire        i_cmp1_out,
  input  wire        i_cmp2_out,
  output reg  [3:0]  o_pwm_out,
  output reg  [3:0]  o_pwm_oe,
  output reg         o_period_timer_flag
);

  // Registers written by software. The shutdown word is kept as two registers
  // so that its status bit, which hardware also sets, has a single owner.
  reg [6:0] sd_cfg_q;         // Source and pair states.
  reg       sd_status_q;      // Shutdown status bit.
  reg [7:0] mode_ctl_q;       // Config, duty low bits, mode.
  reg [7:0] timer_sel_q;      // Timer select field in the low bits.
  reg [7:0] period_q;         // Period register.
  reg [7:0] steer_ctl_q;      // Sync bit and per-pin enables.
  reg [7:0] restart_db_q;     // Auto-restart and dead-band delay.
  reg [7:0] timer_ctl_q;      // Timer on bit and prescale.
  reg [7:0] duty_upper_q;     // Upper eight duty bits.
  reg [3:0] pin_dir_q;        // One direction bit per pin, set means input.
  reg       flag_q;           // Period timer flag, sticky.

  // Timer state.
  reg [7:0] count_q;          // Period timer count.
  reg [3:0] presc_q;          // Prescale counter, also the two low compare bits.
  reg [1:0] duty_low_q;       // Latched low duty bits.
  reg [7:0] duty_hi_q;        // Latched upper duty bits.
  reg       first_done_q;     // First period has already rolled over.
  reg       pwm_q;            // Raw modulated signal.
  reg [3:0] steer_eff_q;      // Steering enables in effect.
  reg       run_q;            // Output running, cleared by shutdown.
  reg [6:0] db_cnt_q;         // Dead-band countdown.
  reg       db_prev_q;        // Last raw level, for edge detection.

  // Two-flop synchronisers for asynchronous inputs.
  reg [2:0] sync1_q;
  reg [2:0] sync2_q;

  wire       fault_low  = ~sync2_q[0];
  wire       cmp1       = sync2_q[1];
  wire       cmp2       = sync2_q[2];
  wire [7:0] shutdown_ctl_q = {sd_status_q, sd_cfg_q}; // Word as software sees it.
  wire [2:0] src        = shutdown_ctl_q[`SD_SRC_HI:`SD_SRC_LO];
  wire       restart_en = restart_db_q[`RD_RESTART_BIT];
  wire [1:0] cfg        = mode_ctl_q[`MC_CFG_HI:`MC_CFG_LO];
  wire [1:0] pol        = mode_ctl_q[1:0];
  wire       timer_on   = timer_ctl_q[`TC_ON_BIT];
  wire [1:0] tsel       = timer_sel_q[1:0];
  wire       local_sel  = (tsel == `TSEL_LOCAL);

  // Shutdown condition from the selected hardware source.
  reg sd_cond;
  always @* begin
    case (src)
      `SRC_OFF:        sd_cond = 1'b0;
      `SRC_CMP1:       sd_cond = cmp1;
      `SRC_CMP2:       sd_cond = cmp2;
      `SRC_CMP_ANY:    sd_cond = cmp1 | cmp2;
      `SRC_FAULT:      sd_cond = fault_low;
      `SRC_FAULT_CMP1: sd_cond = fault_low | cmp1;
      `SRC_FAULT_CMP2: sd_cond = fault_low | cmp2;
      default:         sd_cond = fault_low | cmp1 | cmp2;
    endcase
  end

  // Prescale ratio of 1, 4 or 16 selected by the two-bit field.
  // The unused fourth code also divides by 16, so no setting stops the timer.
  function [3:0] presc_max;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    presc_max = 4'h0;
        2'h1:    presc_max = 4'h3;
        default: presc_max = 4'hf;
      endcase
    end
  endfunction

  // Timer ticks only while on and selected; roll over ends a period.
  wire tick      = timer_on & local_sel & (presc_q == presc_max(timer_ctl_q[1:0]));
  wire roll      = tick & (count_q == period_q);
  wire [9:0] pos = {count_q, presc_q[1:0]};

  // APB decode; zero wait states so pready is high in every access phase.
  // Read data are fetched in the setup cycle, so a read never waits and the
  // value returned is the one held at the setup edge.
  wire apb_wr = i_psel & i_penable & i_pwrite;
  wire apb_rd = i_psel & i_penable & ~i_pwrite;

  function hit;
    input [11:0] a;
    input [11:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  wire known = hit(i_paddr, `OFS_SHUTDOWN_CONTROL) | hit(i_paddr, `OFS_MODE_CONTROL) |
               hit(i_paddr, `OFS_TIMER_SELECT) | hit(i_paddr, `OFS_TIMER_PERIOD) |
               hit(i_paddr, `OFS_STEERING_CONTROL) | hit(i_paddr, `OFS_RESTART_DEADBAND) |
               hit(i_paddr, `OFS_TIMER_CONTROL) | hit(i_paddr, `OFS_TIMER_COUNT) |
               hit(i_paddr, `OFS_DUTY_UPPER) | hit(i_paddr, `OFS_PIN_DIRECTION) |
               hit(i_paddr, `OFS_STATUS);

  wire wr_sd   = apb_wr & hit(i_paddr, `OFS_SHUTDOWN_CONTROL);
  wire wr_stat = apb_wr & hit(i_paddr, `OFS_STATUS);

  // Synchronisers: the first stage feeds only the second.
  // Reset values match the idle level of each pin (fault high, comparators
  // low), so leaving reset never looks like a shutdown event.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sync1_q <= 3'h1;
      sync2_q <= 3'h1;
    end else begin
      sync1_q <= {i_cmp2_out, i_cmp1_out, i_fault_input_pin};
      sync2_q <= sync1_q;
    end
  end

  // Register writes; the shutdown status bit is handled apart below.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sd_cfg_q            <= 7'h00;
      mode_ctl_q          <= `RST_ZERO8;
      timer_sel_q         <= `RST_ZERO8;
      period_q            <= `RST_ZERO8;
      steer_ctl_q         <= `RST_STEERING;
      restart_db_q        <= `RST_ZERO8;
      timer_ctl_q         <= `RST_ZERO8;
      duty_upper_q        <= `RST_ZERO8;
      pin_dir_q           <= `RST_PIN_DIRECTION;
    end else if (apb_wr) begin
      if (hit(i_paddr, `OFS_SHUTDOWN_CONTROL))
        sd_cfg_q <= i_pwdata[6:0];
      if (hit(i_paddr, `OFS_MODE_CONTROL))
        mode_ctl_q <= i_pwdata[7:0];
      if (hit(i_paddr, `OFS_TIMER_SELECT))
        timer_sel_q <= {6'h00, i_pwdata[1:0]};
      if (hit(i_paddr, `OFS_TIMER_PERIOD))
        period_q <= i_pwdata[7:0];
      if (hit(i_paddr, `OFS_STEERING_CONTROL))
        steer_ctl_q <= {3'h0, i_pwdata[4:0]};
      if (hit(i_paddr, `OFS_RESTART_DEADBAND))
        restart_db_q <= i_pwdata[7:0];
      if (hit(i_paddr, `OFS_TIMER_CONTROL))
        timer_ctl_q <= {1'b0, i_pwdata[6:0]};
      if (hit(i_paddr, `OFS_DUTY_UPPER))
        duty_upper_q <= i_pwdata[7:0];
      if (hit(i_paddr, `OFS_PIN_DIRECTION))
        pin_dir_q <= i_pwdata[3:0];
    end
  end

  // Shutdown status: set by hardware or firmware; a hardware condition wins
  // over a firmware clear, since the status bit ignores writes while it persists.
  // Auto-restart clears it only once the condition has gone, and the
  // outputs still wait for the next period start before they resume.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sd_status_q <= 1'b0;
    end else if (sd_cond) begin
      // Level sensitive: the bit is set again on every cycle the source holds.
      sd_status_q <= 1'b1;
    end else if (wr_sd) begin
      sd_status_q <= i_pwdata[`SD_STATUS_BIT];
    end else if (restart_en) begin
      sd_status_q <= 1'b0;
    end
  end

  // The raw condition is ORed in so the run state drops on the same edge as
  // the status bit itself is set, rather than one clock after it.
  wire shut = shutdown_ctl_q[`SD_STATUS_BIT] | sd_cond;

  // Period timer, duty latch at period start, and the period flag.
  // Duty is copied only at roll over, so a new value never cuts a period short.
  // A write to the count word wins over the increment in the same cycle.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      count_q      <= 8'h00;
      presc_q      <= 4'h0;
      duty_hi_q    <= 8'h00;
      duty_low_q   <= 2'h0;
      first_done_q <= 1'b0;
      flag_q       <= 1'b0;
      pwm_q        <= 1'b0;
    end else begin
      if (timer_on & local_sel) begin
        presc_q <= tick ? 4'h0 : presc_q + 4'h1;
        if (tick)
          count_q <= roll ? 8'h00 : count_q + 8'h01;
      end
      if (apb_wr & hit(i_paddr, `OFS_TIMER_COUNT))
        count_q <= i_pwdata[7:0];
      if (roll) begin
        duty_hi_q    <= duty_upper_q;
        duty_low_q   <= mode_ctl_q[`MC_DUTY_HI:`MC_DUTY_LO];
        first_done_q <= 1'b1;
      end
      // The flag rises only from the second roll over on; set beats clear.
      if (roll & first_done_q)
        flag_q <= 1'b1;
      else if (wr_stat & i_pwdata[0])
        flag_q <= 1'b0;
      // Signal is undefined until the first roll over; kept low here.
      pwm_q <= first_done_q & (pos < {duty_hi_q, duty_low_q});
    end
  end

  // Steering, run state and dead-band delay.
  // The run state restarts only at roll over, so after any shutdown the pins
  // pick up again with a whole period. The dead-band counter restarts on
  // every raw edge and holds the newly active side off until it empties.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      steer_eff_q <= 4'h0;
      run_q       <= 1'b0;
      db_cnt_q    <= 7'h00;
      db_prev_q   <= 1'b0;
    end else begin
      if (~steer_ctl_q[`ST_SYNC_BIT] | roll)
        steer_eff_q <= steer_ctl_q[3:0];
      if (shut)
        run_q <= 1'b0;
      else if (roll)
        run_q <= 1'b1;
      db_prev_q <= pwm_q;
      if (pwm_q != db_prev_q)
        db_cnt_q <= restart_db_q[6:0];
      else if (db_cnt_q != 7'h00)
        db_cnt_q <= db_cnt_q - 7'h01;
    end
  end

  // Output mapping per configuration, then polarity, steering and shutdown.
  // Shutdown states override polarity: the programmed level is the pin level.
  // Pins that steering disables stay floating even in shutdown.
  reg [3:0] act;
  reg [3:0] en;
  reg [3:0] lvl;
  reg [3:0] drv;
  integer   i;
  always @* begin
    act = 4'h0;
    en  = 4'hf;
    lvl = 4'h0;
    drv = 4'h0;
    case (cfg)
      `CFG_SINGLE: begin
        act = {4{pwm_q}};
        en  = steer_eff_q;
      end
      `CFG_HALF: begin
        // Each side waits out the dead-band after the other turns off.
        act = {2'b00, ~pwm_q & (db_cnt_q == 7'h00), pwm_q & (db_cnt_q == 7'h00)};
        en  = 4'h3;
      end
      default: begin
        act = {pwm_q & ~cfg[1], 2'b00, ~cfg[1]};
        en  = 4'hf;
      end
    endcase
    for (i = 0; i < 4; i = i + 1) begin
      // Pins a and c use polarity bit 1; b and d use bit 0.
      lvl[i] = ((i == 0) || (i == 2)) ? (act[i] ^ pol[1]) : (act[i] ^ pol[0]);
      if (~run_q) begin
        // Pair a/c uses one state field, pair b/d the other.
        if ((i == 0) || (i == 2)) begin
          lvl[i] = (shutdown_ctl_q[`SD_AC_HI:`SD_AC_LO] == `SDS_DRIVE1);
          drv[i] = en[i] & (shutdown_ctl_q[`SD_AC_HI] == 1'b0);
        end else begin
          lvl[i] = (shutdown_ctl_q[`SD_BD_HI:`SD_BD_LO] == `SDS_DRIVE1);
          drv[i] = en[i] & (shutdown_ctl_q[`SD_BD_HI] == 1'b0);
        end
      end else begin
        drv[i] = en[i];
      end
    end
  end

  // Registered pin and APB outputs.
  // Every output leaves a flip-flop, so the pins see no decode glitches.
  // The pin enables also pass the direction bits, which override all else.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pwm_out           <= 4'h0;
      o_pwm_oe            <= 4'h0;
      o_prdata            <= 32'h00000000;
      o_pready            <= 1'b0;
      o_pslverr           <= 1'b0;
      o_period_timer_flag <= 1'b0;
    end else begin
      o_pwm_out           <= lvl;
      o_pwm_oe            <= drv & ~pin_dir_q;
      o_period_timer_flag <= flag_q;
      o_pready            <= i_psel & ~i_penable;
      o_pslverr           <= i_psel & ~i_penable & ~known;
      o_prdata            <= 32'h00000000;
      if (i_psel & ~i_penable & ~i_pwrite) begin
        case (i_paddr)
          `OFS_SHUTDOWN_CONTROL: o_prdata <= {24'h0, shutdown_ctl_q};
          `OFS_MODE_CONTROL:     o_prdata <= {24'h0, mode_ctl_q};
          `OFS_TIMER_SELECT:     o_prdata <= {24'h0, timer_sel_q};
          `OFS_TIMER_PERIOD:     o_prdata <= {24'h0, period_q};
          `OFS_STEERING_CONTROL: o_prdata <= {24'h0, steer_ctl_q};
          `OFS_RESTART_DEADBAND: o_prdata <= {24'h0, restart_db_q};
          `OFS_TIMER_CONTROL:    o_prdata <= {24'h0, timer_ctl_q};
          `OFS_TIMER_COUNT:      o_prdata <= {24'h0, count_q};
          `OFS_DUTY_UPPER:       o_prdata <= {24'h0, duty_upper_q};
          `OFS_PIN_DIRECTION:    o_prdata <= {28'h0, pin_dir_q};
          `OFS_STATUS:           o_prdata <= {29'h0, run_q, first_done_q, flag_q};
          default:               o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // The read strobe is kept for symmetry with writes; data are latched in setup.
  // It drives no logic.
  wire unused_rd = apb_rd;

endmodule

// [epwm_core_asserts.sv]
// Port checker for the enhanced PWM unit.
// Assumes it is bound to epwm_core and sees its ports only.
`timescale 1ns/10ps
`include "epwm_defs.vh"
module epwm_core_asserts (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        i_fault_input_pin,
  input wire logic        i_cmp1_out,
  input wire logic        i_cmp2_out,
  input wire logic [3:0]  o_pwm_out,
  input wire logic [3:0]  o_pwm_oe,
  input wire logic        o_period_timer_flag
);
  logic [7:0] sd_q;   // Shadow of the shutdown control word.
  logic [3:0] dir_q;  // Shadow of the pin direction word.
  wire        wr = i_psel && i_penable && i_pwrite && o_pready;
  // Shadows follow committed writes, so outputs can be tied to settings.
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      sd_q  <= 8'h00;
      dir_q <= 4'hf;
    end else if (wr) begin
      if (i_paddr == `OFS_SHUTDOWN_CONTROL) sd_q <= i_pwdata[7:0];
      if (i_paddr == `OFS_PIN_DIRECTION) dir_q <= i_pwdata[3:0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_ready_after_setup: assert property ((i_psel && !i_penable) |=> o_pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (o_pready |=> !o_pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  a_unmapped_err: assert property ((i_psel && !i_penable && i_paddr > `OFS_STATUS)
    |=> o_pslverr && o_prdata == 32'h0) else $error("unmapped access not refused");
  a_reset_quiet: assert property ($fell(i_sys_rst) |-> o_pwm_oe == 4'h0 && o_pwm_out == 4'h0)
    else $error("pins driven after reset");
  a_dir_blocks: assert property ((dir_q == $past(dir_q) && dir_q == $past(dir_q, 2))
    |-> (o_pwm_oe & dir_q) == 4'h0) else $error("input pin driven");
  a_flag_clear: assert property ($fell(o_period_timer_flag)
    |-> $past(wr && i_paddr == `OFS_STATUS && i_pwdata[0], 2)) else $error("flag lost");
  a_sd_float_ac: assert property ((sd_q[6] && sd_q[3] && !i_fault_input_pin) [*8]
    |-> (o_pwm_oe & 4'h5) == 4'h0) else $error("a c pair not floating");
  a_sd_low_bd: assert property ((sd_q[6] && sd_q[1:0] == 2'h0 && !i_fault_input_pin) [*8]
    |-> (o_pwm_out & 4'ha) == 4'h0) else $error("b d pair not low");
endmodule
bind epwm_core epwm_core_asserts u_chk (.i_clk, .i_sys_rst, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_fault_input_pin, .i_cmp1_out,
  .i_cmp2_out, .o_pwm_out, .o_pwm_oe, .o_period_timer_flag);

// [bridge_model.sv]
// Power bridge and driver model on the far side of the PWM pins.
// Assumes pull-downs keep every switch off while a pin floats.
`timescale 1ns/10ps
module bridge_model (
  input  wire logic       i_trip,
  input  wire logic [3:0] i_pwm_out,
  input  wire logic [3:0] i_pwm_oe,
  output wire logic       o_fault_n,
  output wire logic [3:0] o_gate
);
  // A floating pin reads as the pull-down level, not the last value.
  assign o_gate = i_pwm_out & i_pwm_oe;
  // The fault line idles high and is pulled low while tripped.
  assign o_fault_n = ~i_trip;
endmodule

// [tb_top.sv]
// Self-checking bench for the enhanced PWM unit.
// Assumes the unit, its header, the checker and the bridge model are compiled first.
`timescale 1ns/10ps
`include "epwm_defs.vh"
module tb_top;
  logic        i_clk, i_sys_rst, psel, penable, pwrite, trip, e, cmp1, cmp2;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [7:0]  q;
  wire  [31:0] prdata;
  wire         pready, pslverr, fault_n, flag;
  wire  [3:0]  pwm_out, pwm_oe, gate;
  int          miscompares, n_compared, k;
  int          mdl [0:9];  // Expected value of each register word but the status word.
  // Writable bits per word; the live count word is read only after reset.
  int          msk [0:9] = '{255, 255, 3, 255, 31, 255, 127, 0, 255, 15};
  epwm_core i_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_fault_input_pin(fault_n), .i_cmp1_out(cmp1), .i_cmp2_out(cmp2),
    .o_pwm_out(pwm_out), .o_pwm_oe(pwm_oe), .o_period_timer_flag(flag));
  bridge_model i_bridge (.i_trip(trip), .i_pwm_out(pwm_out), .i_pwm_oe(pwm_oe),
    .o_fault_n(fault_n), .o_gate(gate));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until ready is seen high at an edge.
  task apb(input logic [11:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) miscompares++;
    q = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] x);
    apb(a, 1'b0, 8'h00);
    chk({e, q}, {1'b0, x});
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task results();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  // Watchdog: far beyond the few hundred cycles the tests need.
  initial begin
    #100000;
    miscompares++;
    results();
  end
  initial begin
    {i_sys_rst, psel, penable, pwrite, trip, cmp1, cmp2} = 7'b1000000;
    paddr = 12'h000;
    pwdata = 32'h0;
    miscompares = 0;
    n_compared = 0;
    k = $urandom(32'ha93ee044);
    cyc(5);
    i_sys_rst <= 1'b0;
    chk({pwm_oe, gate}, 8'h00);
    for (int i = 0; i < 10; i++) mdl[i] = (i == 4) ? 1 : (i == 9) ? 15 : 0;
    for (int i = 0; i < 10; i++) rd(12'(i * 4), 8'(mdl[i]));
    // Random values through every register word but the count and status words, checked against the model.
    for (int i = 0; i < 10; i++) begin
      if (i == 7) continue;
      mdl[i] = $urandom & msk[i];
      wr(12'(i * 4), 8'(mdl[i]));
      rd(12'(i * 4), 8'(mdl[i]));
    end
    wr(12'h02c, 8'h5a);
    chk(e, 1'b1);
    apb(12'h02c, 1'b0, 8'h00);
    chk({e, q}, 9'h100);
    i_sys_rst <= 1'b1;
    cyc(5);
    i_sys_rst <= 1'b0;
    chk({pwm_oe, gate}, 8'h00);
    // Start-up in forced shutdown: a c pair floats, b d pair driven low.
    wr(`OFS_STEERING_CONTROL, 8'h0f);
    wr(`OFS_TIMER_SELECT, 8'h00);
    wr(`OFS_TIMER_PERIOD, 8'h03);
    wr(`OFS_SHUTDOWN_CONTROL, 8'hc8);
    wr(`OFS_RESTART_DEADBAND, 8'h00);
    wr(`OFS_MODE_CONTROL, 8'h0c);
    wr(`OFS_DUTY_UPPER, 8'h00);
    wr(`OFS_TIMER_CONTROL, 8'h04);
    k = 0;
    while (flag !== 1'b1 && k < 200) begin
      @(posedge i_clk);
      k++;
    end
    chk(32'(k >= 5 && k <= 20), 1);
    apb(`OFS_STATUS, 1'b0, 8'h00);
    chk(q[2:0], 3'h3);
    wr(`OFS_STATUS, 8'h01);
    wr(`OFS_PIN_DIRECTION, 8'h00);
    cyc(3);
    chk({pwm_oe, gate}, 8'ha0);
    wr(`OFS_SHUTDOWN_CONTROL, 8'h48);
    cyc(12);
    chk(pwm_oe, 4'hf);
    // Polarity changes only with the drivers off; latch levels still show.
    wr(`OFS_PIN_DIRECTION, 8'h0f);
    for (int m = 0; m < 4; m++) begin
      wr(`OFS_MODE_CONTROL, 8'(12 + m));
      cyc(10);
      chk(pwm_out, {m[0], m[1], m[0], m[1]});
    end
    wr(`OFS_MODE_CONTROL, 8'h0c);
    wr(`OFS_PIN_DIRECTION, 8'h00);
    wr(`OFS_DUTY_UPPER, 8'hff);
    wr(`OFS_STEERING_CONTROL, 8'h01);
    cyc(8);
    chk(gate, 4'h1);
    wr(`OFS_STEERING_CONTROL, 8'h0f);
    wr(`OFS_RESTART_DEADBAND, 8'h80);
    trip <= 1'b1;
    cyc(10);
    chk({pwm_oe, gate}, 8'ha0);
    wr(`OFS_SHUTDOWN_CONTROL, 8'h48);
    rd(`OFS_SHUTDOWN_CONTROL, 8'hc8);
    trip <= 1'b0;
    cyc(20);
    rd(`OFS_SHUTDOWN_CONTROL, 8'h48);
    chk({pwm_oe, gate}, 8'hff);
    // Half-bridge: full duty keeps the high side on and the low side off.
    wr(`OFS_MODE_CONTROL, 8'h8c);
    cyc(10);
    chk({pwm_oe, gate}, 8'h31);
    wr(`OFS_MODE_CONTROL, 8'h0c);
    // Comparator sources: a c pair floats, b d pair driven high.
    for (int s = 1; s < 3; s++) begin
      wr(`OFS_SHUTDOWN_CONTROL, 8'(s * 16 + 13));
      if (s == 1) cmp1 <= 1'b1;
      else cmp2 <= 1'b1;
      cyc(10);
      chk({pwm_oe, gate}, 8'haa);
      rd(`OFS_SHUTDOWN_CONTROL, 8'(s * 16 + 141));
      {cmp1, cmp2} <= 2'b00;
      cyc(20);
      rd(`OFS_SHUTDOWN_CONTROL, 8'(s * 16 + 13));
    end
    results();
  end
endmodule
